// ===== hw/sau_pkg.sv
/*
  Shared constants and types for the stack arithmetic unit: register map,
  reset values, field positions, opcode and state encodings, flag layouts.
  Assumes a 32-bit classic Wishbone slave port with byte addressing.
*/
package sau_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STACK_DEPTH = 8;

  // Register byte offsets
  localparam logic [7:0] OFS_COMMAND = 8'h00;
  localparam logic [7:0] OFS_ACC = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_INT_STATUS = 8'h0C;
  localparam logic [7:0] OFS_INT_MASK = 8'h10;
  localparam logic [7:0] OFS_STACK_BASE = 8'h20;
  localparam logic [2:0] STACK_PAGE = 3'h1;

  // Command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BUSY_BIT = 8;

  // Reset values
  localparam logic [31:0] RST_ACC = 32'h0000_0000;
  localparam logic [31:0] RST_STACK = 32'h0000_0000;
  localparam logic [6:0] RST_FLAGS = 7'h00;
  localparam logic [3:0] RST_INT_STATUS = 4'h0;
  localparam logic [3:0] RST_INT_MASK = 4'h0;

  // Divider runs one quotient bit per cycle
  localparam logic [4:0] DIV_LAST_STEP = 5'h1F;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_BCD_STACK_MULTIPLY = 3'h1,
    OP_BCD_STACK_DIVIDE = 3'h2,
    OP_BINARY_STACK_ADD = 3'h3,
    OP_BINARY_STACK_SUBTRACT = 3'h4,
    OP_BINARY_STACK_MULTIPLY = 3'h5
  } sau_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_DIVIDE = 2'h1,
    ST_FINISH = 2'h3
  } sau_state_t;

  typedef struct packed {
    logic sign_error_flag;
    logic borrow_flag;
    logic carry_flag;
    logic operand_overflow_flag;
    logic invalid_bcd_flag;
    logic negative_flag;
    logic zero_flag;
  } sau_flags_t;

  typedef struct packed {
    logic sign_error;
    logic operand_overflow;
    logic invalid_bcd;
    logic op_done;
  } sau_int_t;

endpackage

// ===== hw/sau_stack_arith_unit.sv
/*
  Stack arithmetic unit: accumulator, eight-level accumulator stack, status
  flags and the BCD/binary stack operations, reached over classic Wishbone.
  Assumes one clock, a synchronous active-low reset and a master that issues
  one command at a time and waits for busy to fall before the next.
*/
// Operation
// - BCD multiply: four-digit stack level 1 times four-digit accumulator into accumulator
// - After BCD multiply or binary add/subtract/multiply, pop level 1, shift deeper levels up
// - BCD divide: eight-digit accumulator by four-digit level 1, quotient to accumulator
// - BCD divide writes remainder into level 1; deeper levels stay unchanged
// - Binary add: accumulator plus level 1 into accumulator
// - Binary subtract: accumulator minus level 1 into accumulator
// - Binary multiply: 16-bit level 1 times 16-bit accumulator, 32-bit product kept
// - Every operation sets zero flag when accumulator result is zero
// - Binary add, subtract and multiply set negative flag when accumulator result is negative; BCD operations clear it
// - BCD multiply and divide flag any illegal BCD operand digit
// - BCD divide flags operand overflow when operand exceeds accumulator capability
// - Binary add sets carry on carry out of bit 31
// - Binary subtract sets borrow when subtraction borrows
// - Binary add and subtract set sign error on signed overflow
// - A flag holds until the next operation updating that flag
// - Loading the accumulator pushes old contents into level 1, others one deeper
`timescale 1ns/10ps
`default_nettype none

module sau_stack_arith_unit #(
  parameter int DEPTH = sau_pkg::STACK_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [sau_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  output logic busy,
  output sau_pkg::sau_flags_t status_flags
);

  function automatic logic [31:0] bcd_to_bin(input logic [31:0] x);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 7; i >= 0; i--)
      r = (r << 3) + (r << 1) + {28'h000_0000, x[i*4 +: 4]};
    return r;
  endfunction

  function automatic logic [31:0] bin_to_bcd(input logic [31:0] b);
    logic [39:0] d;
    d = 40'h00_0000_0000;
    for (int i = 31; i >= 0; i--)
    begin
      for (int k = 0; k < 10; k++)
        if (d[k*4 +: 4] > 4'h4)
          d[k*4 +: 4] = d[k*4 +: 4] + 4'h3;
      d = {d[38:0], b[i]};
    end
    return d[31:0];
  endfunction

  function automatic logic bcd_bad(input logic [31:0] x, input logic wide);
    logic bad;
    bad = 1'b0;
    for (int i = 0; i < 8; i++)
      if ((i < 4 || wide) && x[i*4 +: 4] > 4'h9)
        bad = 1'b1;
    return bad;
  endfunction

  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  sau_pkg::sau_state_t state;
  sau_pkg::sau_op_t op, cmd_op;
  logic [31:0] acc, opa, opb, quo, result, rem_bcd, final_acc, mul_a, mul_b, product, bcd_acc_bin, div_bin;
  logic [31:0] stack_level [DEPTH], push_src [DEPTH], pop_src [DEPTH];
  logic op_bad, op_ovf, bus_req, bus_wr, start, do_push, do_pop, do_rem, commit, fits;
  logic [32:0] sum33, diff33;
  logic [16:0] rem, rem_shift;
  logic [15:0] divisor;
  logic [7:0] bus_adr;
  logic [4:0] div_step;
  logic [3:0] int_mask;
  sau_pkg::sau_int_t int_status, events;
  sau_pkg::sau_flags_t next_flags;

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i;
  assign bus_adr = {wb_adr_i[7:2], 2'b00};
  assign busy = (state != sau_pkg::ST_IDLE);
  assign cmd_op = sau_pkg::sau_op_t'(wb_dat_i[sau_pkg::CMD_OP_LSB +: 3]);
  // Commands while busy are dropped; the sequencer must poll busy first
  assign start = bus_wr && bus_adr == sau_pkg::OFS_COMMAND && wb_sel_i[0] && !busy
    && cmd_op inside {sau_pkg::OP_BCD_STACK_MULTIPLY, sau_pkg::OP_BCD_STACK_DIVIDE,
    sau_pkg::OP_BINARY_STACK_ADD, sau_pkg::OP_BINARY_STACK_SUBTRACT, sau_pkg::OP_BINARY_STACK_MULTIPLY};
  assign do_push = bus_wr && bus_adr == sau_pkg::OFS_ACC && !busy;
  assign do_pop = state == sau_pkg::ST_FINISH && commit && op != sau_pkg::OP_BCD_STACK_DIVIDE;
  assign do_rem = state == sau_pkg::ST_FINISH && commit && op == sau_pkg::OP_BCD_STACK_DIVIDE;
  assign bcd_acc_bin = bcd_to_bin(acc);

  // Shared multiplier: BCD operands are converted to binary first
  assign product = mul_a[15:0] * mul_b[15:0];
  assign sum33 = {1'b0, opa} + {1'b0, opb};
  assign diff33 = {1'b0, opa} - {1'b0, opb};
  assign rem_shift = {rem[15:0], quo[31]};
  assign rem_bcd = bin_to_bcd({15'h0000, rem});

  assign mul_a = (op == sau_pkg::OP_BCD_STACK_MULTIPLY) ? bcd_to_bin({16'h0000, opa[15:0]}) : opa;
  assign mul_b = (op == sau_pkg::OP_BCD_STACK_MULTIPLY) ? bcd_to_bin({16'h0000, opb[15:0]}) : opb;
  assign div_bin = bcd_to_bin({16'h0000, stack_level[0][15:0]});
  assign fits = rem_shift >= {1'b0, divisor};

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      state <= sau_pkg::ST_IDLE;
    else
      unique case (state)
        sau_pkg::ST_IDLE:
        begin
          if (start)
          begin
            if (cmd_op == sau_pkg::OP_BCD_STACK_DIVIDE && !bcd_bad(acc, 1'b1) && !bcd_bad(stack_level[0], 1'b0)
                && stack_level[0][31:16] == 16'h0000 && stack_level[0][15:0] != 16'h0000)
              state <= sau_pkg::ST_DIVIDE;
            else
              state <= sau_pkg::ST_FINISH;
          end
        end
        sau_pkg::ST_DIVIDE:
        begin
          if (div_step == sau_pkg::DIV_LAST_STEP)
            state <= sau_pkg::ST_FINISH;
        end
        sau_pkg::ST_FINISH:
          state <= sau_pkg::ST_IDLE;
        default:
          state <= sau_pkg::ST_IDLE;
      endcase
  end

  // Operands are frozen at start so a long divide sees stable inputs
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      op <= sau_pkg::OP_NONE;
      opa <= sau_pkg::RST_ACC;
      opb <= sau_pkg::RST_STACK;
      op_bad <= 1'b0;
      op_ovf <= 1'b0;
    end
    else if (start)
    begin
      op <= cmd_op;
      opa <= acc;
      opb <= stack_level[0];
      op_bad <= (cmd_op == sau_pkg::OP_BCD_STACK_MULTIPLY && (bcd_bad(acc, 1'b0) || bcd_bad(stack_level[0], 1'b0)))
        || (cmd_op == sau_pkg::OP_BCD_STACK_DIVIDE && (bcd_bad(acc, 1'b1) || bcd_bad(stack_level[0], 1'b0)));
      op_ovf <= stack_level[0][31:16] != 16'h0000 || stack_level[0][15:0] == 16'h0000;
    end
  end

  // Restoring divider, one quotient bit per cycle
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      quo <= 32'h0000_0000;
      rem <= 17'h0_0000;
      divisor <= 16'h0000;
      div_step <= 5'h00;
    end
    else if (start)
    begin
      quo <= bcd_acc_bin;
      rem <= 17'h0_0000;
      divisor <= div_bin[15:0];
      div_step <= 5'h00;
    end
    else if (state == sau_pkg::ST_DIVIDE)
    begin
      div_step <= div_step + 5'h01;
      rem <= fits ? rem_shift - {1'b0, divisor} : rem_shift;
      quo <= {quo[30:0], fits};
    end
  end

  always_comb
  begin
    result = acc;
    commit = 1'b0;
    next_flags = status_flags;
    unique case (op)
      sau_pkg::OP_BCD_STACK_MULTIPLY:
      begin
        commit = !op_bad;
        result = bin_to_bcd(product);
        next_flags.invalid_bcd_flag = op_bad;
      end
      sau_pkg::OP_BCD_STACK_DIVIDE:
      begin
        commit = !op_bad && !op_ovf;
        result = bin_to_bcd(quo);
        next_flags.invalid_bcd_flag = op_bad;
        next_flags.operand_overflow_flag = op_ovf;
      end
      sau_pkg::OP_BINARY_STACK_ADD:
      begin
        commit = 1'b1;
        result = sum33[31:0];
        next_flags.carry_flag = sum33[32];
        next_flags.sign_error_flag = opa[31] == opb[31] && sum33[31] != opa[31];
      end
      sau_pkg::OP_BINARY_STACK_SUBTRACT:
      begin
        commit = 1'b1;
        result = diff33[31:0];
        next_flags.borrow_flag = diff33[32];
        next_flags.sign_error_flag = opa[31] != opb[31] && diff33[31] != opa[31];
      end
      sau_pkg::OP_BINARY_STACK_MULTIPLY:
      begin
        commit = 1'b1;
        result = product;
      end
      default:
      begin
        commit = 1'b0;
      end
    endcase
    final_acc = commit ? result : acc;
    next_flags.zero_flag = final_acc == 32'h0000_0000;
    // Packed BCD carries no sign, so BCD results never read as negative
    next_flags.negative_flag = final_acc[31] && op != sau_pkg::OP_BCD_STACK_MULTIPLY
      && op != sau_pkg::OP_BCD_STACK_DIVIDE;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      acc <= sau_pkg::RST_ACC;
    else if (do_push)
      acc <= lane_merge(acc, wb_dat_i, wb_sel_i);
    else if (state == sau_pkg::ST_FINISH)
      acc <= final_acc;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      status_flags <= sau_pkg::sau_flags_t'(sau_pkg::RST_FLAGS);
    else if (state == sau_pkg::ST_FINISH)
      status_flags <= next_flags;
  end

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : gen_stack
      if (g == 0)
        assign push_src[g] = acc;
      else
        assign push_src[g] = stack_level[g-1];
      if (g == DEPTH - 1)
        assign pop_src[g] = sau_pkg::RST_STACK;
      else
        assign pop_src[g] = stack_level[g+1];

      always_ff @(posedge sys_clk)
      begin
        if (!rst_n)
          stack_level[g] <= sau_pkg::RST_STACK;
        else if (do_push)
          stack_level[g] <= push_src[g];
        else if (do_pop)
          stack_level[g] <= pop_src[g];
        else if (do_rem && g == 0)
          stack_level[g] <= rem_bcd;
      end
    end
  endgenerate

  always_comb
  begin
    events.op_done = state == sau_pkg::ST_FINISH;
    events.invalid_bcd = events.op_done && next_flags.invalid_bcd_flag && op != sau_pkg::OP_BINARY_STACK_ADD
      && op != sau_pkg::OP_BINARY_STACK_SUBTRACT && op != sau_pkg::OP_BINARY_STACK_MULTIPLY;
    events.operand_overflow = events.op_done && op == sau_pkg::OP_BCD_STACK_DIVIDE && op_ovf;
    events.sign_error = events.op_done && (op == sau_pkg::OP_BINARY_STACK_ADD
      || op == sau_pkg::OP_BINARY_STACK_SUBTRACT) && next_flags.sign_error_flag;
  end

  // New events win over a same-cycle write-one-to-clear
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      int_status <= sau_pkg::sau_int_t'(sau_pkg::RST_INT_STATUS);
    else if (bus_wr && bus_adr == sau_pkg::OFS_INT_STATUS && wb_sel_i[0])
      int_status <= (int_status & ~sau_pkg::sau_int_t'(wb_dat_i[3:0])) | events;
    else
      int_status <= int_status | events;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      int_mask <= sau_pkg::RST_INT_MASK;
    else if (bus_wr && bus_adr == sau_pkg::OFS_INT_MASK && wb_sel_i[0])
      int_mask <= wb_dat_i[3:0];
  end

  assign irq = |(int_status & int_mask);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= bus_req;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      wb_dat_o <= 32'h0000_0000;
    else if (bus_req && !wb_we_i)
    begin
      wb_dat_o <= 32'h0000_0000;
      if (bus_adr == sau_pkg::OFS_COMMAND)
      begin
        wb_dat_o[sau_pkg::CMD_OP_LSB +: 3] <= op;
        wb_dat_o[sau_pkg::CMD_BUSY_BIT] <= busy;
      end
      else if (bus_adr == sau_pkg::OFS_ACC)
        wb_dat_o <= acc;
      else if (bus_adr == sau_pkg::OFS_FLAGS)
        wb_dat_o[6:0] <= status_flags;
      else if (bus_adr == sau_pkg::OFS_INT_STATUS)
        wb_dat_o[3:0] <= int_status;
      else if (bus_adr == sau_pkg::OFS_INT_MASK)
        wb_dat_o[3:0] <= int_mask;
      else if (bus_adr[7:5] == sau_pkg::STACK_PAGE && int'(bus_adr[4:2]) < DEPTH)
        wb_dat_o <= stack_level[bus_adr[4:2]];
    end
  end

endmodule

`default_nettype wire

// ===== tb/sau_properties.sv
/*
  Concurrent checks on the ports of the stack arithmetic unit.
  Assumes one clock, synchronous active-low reset, bound by the statement below.
*/
`timescale 1ns/10ps
`default_nettype none

module sau_properties #(
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [sau_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic irq,
  input wire logic busy,
  input wire sau_pkg::sau_flags_t status_flags
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_cmd;
    s_req ##0 (wb_we_i && wb_adr_i[7:2] == 6'h00 && wb_sel_i[0] && !busy && wb_dat_i[2:0] inside {[3'h1:3'h5]});
  endsequence

  property p_ack_resp;
    s_req |=> wb_ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("request not acknowledged next cycle");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_op_start;
    s_cmd |=> busy;
  endproperty
  a_op_start: assert property (p_op_start) else $error("busy did not rise on command");
  property p_short_op;
    s_cmd ##0 (wb_dat_i[2:0] != 3'h2) |=> busy ##[1:2] !busy;
  endproperty
  a_short_op: assert property (p_short_op) else $error("short operation length wrong");
  property p_busy_bound;
    $rose(busy) |-> ##[1:33] !busy;
  endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("operation did not finish");
  property p_flags_at_end;
    $changed(status_flags) |-> $past(busy);
  endproperty
  a_flags_at_end: assert property (p_flags_at_end) else $error("flags changed outside an operation");
  property p_zero_neg;
    status_flags.zero_flag |-> !status_flags.negative_flag;
  endproperty
  a_zero_neg: assert property (p_zero_neg) else $error("zero and negative both set");
  property p_irq_cause;
    $rose(irq) |-> $past(busy) || $past(wb_cyc_i && wb_stb_i && wb_we_i);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt rose without cause");
endmodule

bind sau_stack_arith_unit sau_properties #(.DEPTH(DEPTH)) u_props (.sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .busy, .status_flags);

`default_nettype wire

// ===== tb/sau_seq_model.sv
/*
  Sequencer model: classic Wishbone master issuing one transfer at a time.
  Assumes the slave answers with a registered ack; the bench bounds waits.
*/
`timescale 1ns/10ps
`default_nettype none

module sau_seq_model (
  input wire logic sys_clk,
  output logic wb_cyc_i,
  output logic wb_stb_i,
  output logic wb_we_i,
  output logic [7:0] wb_adr_i,
  output logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o
);
  initial
  begin
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0000_0000;
  end

  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    // Released data no longer shows the old word
    wb_dat_i <= ~d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0000_0000, q);
  endtask
endmodule

`default_nettype wire

// ===== tb/test_stack_arith_unit.sv
/*
  Self-checking bench for the stack arithmetic unit: loads, each operation,
  refused commands, flag history, interrupts and an unmapped address.
  Assumes the sequencer model in sau_seq_model and the bound checker.
*/
`timescale 1ns/10ps
`default_nettype none

module test_stack_arith_unit;
  localparam logic [31:0] SENT = 32'h0000_0777;
  logic sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, busy;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  sau_pkg::sau_flags_t status_flags;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;

  sau_stack_arith_unit uut (.sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .busy, .status_flags);
  sau_seq_model seq (.sys_clk, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_ack_o, .wb_dat_o);

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_idle();
    int i;
    for (i = 0; i < 100 && busy !== 1'b0; i++) @(posedge sys_clk);
    chk("busy", 32'h0000_0000, {31'h0, busy});
  endtask

  task automatic reset_case();
    logic [7:0] a[6] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h20, 8'h3C};
    logic [31:0] d;
    foreach (a[i])
    begin
      seq.rd(a[i], d);
      chk("reset value", 32'h0000_0000, d);
    end
    seq.wr(8'h18, 32'hFFFF_FFFF);
    seq.rd(8'h18, d);
    chk("unmapped", 32'h0000_0000, d);
  endtask

  // Push sentinel, l1, a; run op; judge acc, stack and flags
  task automatic run_op(input logic [31:0] l1, input logic [31:0] a, input logic [2:0] op,
    input logic [31:0] e_acc, input logic [31:0] e_l1, input logic [6:0] e_fl);
    logic [31:0] d;
    seq.wr(8'h04, SENT);
    seq.wr(8'h04, l1);
    seq.wr(8'h04, a);
    seq.rd(8'h20, d);
    chk("level1 after load", l1, d);
    seq.rd(8'h24, d);
    chk("level2 after load", SENT, d);
    seq.wr(8'h00, {29'h0, op});
    // A second command during a long divide must be ignored
    if (op == 3'h2 && l1 != 32'h0000_0000)
    begin
      seq.wr(8'h00, 32'h0000_0003);
      seq.rd(8'h00, d);
      chk("busy bit", 32'h0000_0102, d);
    end
    wait_idle();
    seq.rd(8'h00, d);
    chk("command reg", {29'h0, op}, d);
    seq.rd(8'h04, d);
    chk("acc", e_acc, d);
    seq.rd(8'h20, d);
    chk("level1", e_l1, d);
    if (e_l1 != SENT)
    begin
      seq.rd(8'h24, d);
      chk("level2 kept", SENT, d);
    end
    seq.rd(8'h08, d);
    chk("flags reg", {25'h0, e_fl}, d);
    chk("flags port", {25'h0, e_fl}, {25'h0, status_flags});
  endtask

  task automatic irq_case();
    logic [31:0] d;
    seq.rd(8'h0C, d);
    chk("int status", 32'h0000_000F, d);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    seq.wr(8'h10, 32'h0000_0001);
    chk("irq unmasked", 32'h0000_0001, {31'h0, irq});
    seq.wr(8'h0C, 32'h0000_0001);
    chk("irq cleared", 32'h0000_0000, {31'h0, irq});
    seq.wr(8'h10, 32'h0000_0008);
    chk("irq other bit", 32'h0000_0001, {31'h0, irq});
    seq.wr(8'h0C, 32'h0000_000E);
    seq.rd(8'h0C, d);
    chk("int status cleared", 32'h0000_0000, d);
    chk("irq off", 32'h0000_0000, {31'h0, irq});
  endtask

  initial
  begin
    rst_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    reset_case();
    run_op(32'h0000_1234, 32'h0000_0056, 3'h1, 32'h0006_9104, SENT, 7'h00);
    run_op(32'h0000_0007, 32'h0000_0100, 3'h2, 32'h0000_0014, 32'h0000_0002, 7'h00);
    run_op(32'h8000_0000, 32'h8000_0000, 3'h3, 32'h0000_0000, SENT, 7'h51);
    run_op(32'h0000_0001, 32'h0000_0000, 3'h4, 32'hFFFF_FFFF, SENT, 7'h32);
    run_op(32'h0000_FFFF, 32'h0000_FFFF, 3'h5, 32'hFFFE_0001, SENT, 7'h32);
    run_op(32'h0000_000A, 32'h0000_0002, 3'h1, 32'h0000_0002, 32'h0000_000A, 7'h34);
    run_op(32'h0000_0000, 32'h0000_0005, 3'h2, 32'h0000_0005, 32'h0000_0000, 7'h38);
    run_op(32'h0000_0000, 32'h0000_9999, 3'h1, 32'h0000_0000, SENT, 7'h39);
    irq_case();
    close_out();
  end
endmodule

`default_nettype wire
